/* File: verilog/fmtf_pkg.sv */
// Constants, types and coding functions shared by the track formatter.
// Assumes a system clock domain and a separate head link clock domain.
package fmtf_pkg;

  // ------------------------------------------------------------------
  // Track layout
  // ------------------------------------------------------------------
  localparam int unsigned PSI_W          = 10;
  localparam logic [5:0]  TRACK_LAST     = 6'h27;
  localparam logic [3:0]  SECTOR_LAST    = 4'hF;
  localparam logic [7:0]  LEN_GAP_INDEX  = 8'h10;
  localparam logic [7:0]  LEN_SYNC       = 8'h06;
  localparam logic [7:0]  LEN_ONE        = 8'h01;
  localparam logic [7:0]  LEN_CRC        = 8'h02;
  localparam logic [7:0]  LEN_GAP_ID     = 8'h0B;
  localparam logic [7:0]  LEN_DATA       = 8'h80;
  localparam logic [7:0]  LEN_GAP_DATA   = 8'h1B;
  localparam logic [7:0]  LEN_GAP_TRACK  = 8'h65;
  localparam logic [7:0]  RD_ID_REMAIN   = 8'h06;
  localparam logic [7:0]  RD_DATA_REMAIN = 8'h82;

  // ------------------------------------------------------------------
  // Byte and clock patterns
  // ------------------------------------------------------------------
  localparam logic [7:0]  BYTE_GAP       = 8'hFF;
  localparam logic [7:0]  BYTE_SYNC      = 8'h00;
  localparam logic [7:0]  MARK_ADDR      = 8'hFE;
  localparam logic [7:0]  MARK_DATA      = 8'hFB;
  localparam logic [7:0]  MARK_DELETED   = 8'hF8;
  localparam logic [7:0]  CLK_MARK       = 8'hC7;
  localparam logic [7:0]  CLK_NORMAL     = 8'hFF;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_PRESET     = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD       = 16'h0000;
  localparam logic [3:0]  CELL_LAST      = 4'hF;

  // ------------------------------------------------------------------
  // Mark kinds and formatter states
  // ------------------------------------------------------------------
  localparam logic [1:0]  KIND_NONE      = 2'h0;
  localparam logic [1:0]  KIND_ID        = 2'h1;
  localparam logic [1:0]  KIND_DATA      = 2'h2;
  localparam logic [1:0]  KIND_DELETED   = 2'h3;

  typedef enum logic [4:0] {
    S_IDLE, S_GAP_IDX, S_SYNC_ID, S_AMARK, S_TRK, S_Z1, S_SEC, S_Z2,
    S_ACRC, S_GAP_ID, S_SYNC_DAT, S_DMARK, S_DATA, S_DCRC, S_GAP_DAT,
    S_GAP_TRK
  } fmtf_state_t;

  // Interleaves clock and data bits, cell zero in the top two bits.
  function automatic logic [15:0] fm_word(input logic [7:0] clk_pat,
                                          input logic [7:0] data);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      w[2*i+1] = clk_pat[i];
      w[2*i]   = data[i];
    end
    return w;
  endfunction : fm_word

  // Extracts the data bits of one received byte window.
  function automatic logic [7:0] fm_data(input logic [15:0] w);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d[i] = w[2*i];
    end
    return d;
  endfunction : fm_data

  // Advances the check word by one byte, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0]  data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_byte

endpackage : fmtf_pkg

/* File: verilog/fmtf_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock as the buffer.
module fmtf_buf #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != CW'(DEPTH));
    end
  end

endmodule : fmtf_buf

/* File: verilog/fmtf_formatter.sv */
// Track formatter and field reader for soft-sectored mini-floppy tracks.
// Assumes a head link clock on clk_link and a user stream on clk_sys.
module fmtf_formatter
  import fmtf_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       clk_link,
  input  wire logic                       fmt_start,
  input  wire logic [fmtf_pkg::PSI_W-1:0] fmt_psi,
  input  wire logic                       fmt_deleted,
  input  wire logic                       wr_valid,
  input  wire logic [7:0]                 wr_data,
  output logic                            wr_ready,
  output logic                            fmt_busy,
  output logic                            fmt_done,
  output logic                            fmt_range_err,
  output logic                            head_wr_gate,
  output logic                            head_wr_cell,
  input  wire logic                       head_rd_cell,
  output logic                            rd_mark_valid,
  output logic [1:0]                      rd_mark_kind,
  output logic                            rd_valid,
  output logic [7:0]                      rd_data,
  output logic                            rd_field_done,
  output logic                            rd_crc_err
);
  import fmtf_pkg::*;

  fmtf_state_t state_q;
  fmtf_state_t state_n;
  logic [7:0]  cnt_q;
  logic [7:0]  len_m1;
  logic [3:0]  sec_q;
  logic [5:0]  trk_q;
  logic        del_q;
  logic [15:0] crc_q;
  logic [7:0]  byte_c;
  logic [7:0]  clk_c;
  logic        emit;
  logic        buf_valid;
  logic [7:0]  buf_data;
  logic        buf_pop;
  logic [15:0] word_q;
  logic        req_q;
  logic        ack_s1_q;
  logic        ack_s2_q;
  logic        lack_q;
  logic        slot_free;

  // ------------------------------------------------------------------
  // Write data buffer
  // ------------------------------------------------------------------
  fmtf_buf #(
    .W     (8),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk_sys),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // ------------------------------------------------------------------
  // Byte sequencer
  // ------------------------------------------------------------------
  assign slot_free = (ack_s2_q == req_q);
  assign emit      = (state_q != S_IDLE) && slot_free &&
                     ((state_q != S_DATA) || buf_valid);
  assign buf_pop   = emit && (state_q == S_DATA);

  always_comb begin
    byte_c  = BYTE_GAP;
    clk_c   = CLK_NORMAL;
    len_m1  = LEN_ONE - 8'h01;
    state_n = state_q;
    case (state_q)
      S_GAP_IDX: begin
        len_m1  = LEN_GAP_INDEX - 8'h01;
        state_n = S_SYNC_ID;
      end
      S_SYNC_ID: begin
        byte_c  = BYTE_SYNC;
        len_m1  = LEN_SYNC - 8'h01;
        state_n = S_AMARK;
      end
      S_AMARK: begin
        byte_c  = MARK_ADDR;
        clk_c   = CLK_MARK;
        state_n = S_TRK;
      end
      S_TRK: begin
        byte_c  = {2'b00, trk_q};
        state_n = S_Z1;
      end
      S_Z1: begin
        byte_c  = BYTE_SYNC;
        state_n = S_SEC;
      end
      S_SEC: begin
        byte_c  = {4'h0, sec_q};
        state_n = S_Z2;
      end
      S_Z2: begin
        byte_c  = BYTE_SYNC;
        state_n = S_ACRC;
      end
      S_ACRC: begin
        byte_c  = (cnt_q == 8'h00) ? crc_q[15:8] : crc_q[7:0];
        len_m1  = LEN_CRC - 8'h01;
        state_n = S_GAP_ID;
      end
      S_GAP_ID: begin
        len_m1  = LEN_GAP_ID - 8'h01;
        state_n = S_SYNC_DAT;
      end
      S_SYNC_DAT: begin
        byte_c  = BYTE_SYNC;
        len_m1  = LEN_SYNC - 8'h01;
        state_n = S_DMARK;
      end
      S_DMARK: begin
        byte_c  = del_q ? MARK_DELETED : MARK_DATA;
        clk_c   = CLK_MARK;
        state_n = S_DATA;
      end
      S_DATA: begin
        byte_c  = buf_data;
        len_m1  = LEN_DATA - 8'h01;
        state_n = S_DCRC;
      end
      S_DCRC: begin
        byte_c  = (cnt_q == 8'h00) ? crc_q[15:8] : crc_q[7:0];
        len_m1  = LEN_CRC - 8'h01;
        state_n = S_GAP_DAT;
      end
      S_GAP_DAT: begin
        len_m1  = LEN_GAP_DATA - 8'h01;
        state_n = (sec_q == SECTOR_LAST) ? S_GAP_TRK : S_SYNC_ID;
      end
      S_GAP_TRK: begin
        len_m1  = LEN_GAP_TRACK - 8'h01;
        state_n = S_IDLE;
      end
      default: begin
        state_n = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q       <= S_IDLE;
      cnt_q         <= 8'h00;
      sec_q         <= 4'h0;
      trk_q         <= 6'h00;
      del_q         <= 1'b0;
      fmt_busy      <= 1'b0;
      fmt_done      <= 1'b0;
      fmt_range_err <= 1'b0;
    end else begin
      fmt_done      <= 1'b0;
      fmt_range_err <= 1'b0;
      if (state_q == S_IDLE) begin
        if (fmt_start) begin
          if (fmt_psi[9:4] > TRACK_LAST) begin
            fmt_range_err <= 1'b1;
          end else begin
            trk_q    <= fmt_psi[9:4];
            del_q    <= fmt_deleted;
            sec_q    <= 4'h0;
            cnt_q    <= 8'h00;
            state_q  <= S_GAP_IDX;
            fmt_busy <= 1'b1;
          end
        end
      end else if (emit) begin
        if (cnt_q == len_m1) begin
          cnt_q   <= 8'h00;
          state_q <= state_n;
          if (state_q == S_GAP_DAT) begin
            sec_q <= sec_q + 4'h1;
          end
          if (state_q == S_GAP_TRK) begin
            fmt_busy <= 1'b0;
            fmt_done <= 1'b1;
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Field check word
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crc_q <= CRC_PRESET;
    end else if (emit) begin
      case (state_q)
        S_AMARK, S_DMARK: begin
          crc_q <= crc_byte(CRC_PRESET, byte_c);
        end
        S_TRK, S_Z1, S_SEC, S_Z2, S_DATA: begin
          crc_q <= crc_byte(crc_q, byte_c);
        end
        default: begin
          crc_q <= crc_q;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Word hand-over to the link domain
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_q   <= 16'h0000;
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= lack_q;
      ack_s2_q <= ack_s1_q;
      if (emit) begin
        word_q <= fm_word(clk_c, byte_c);
        req_q  <= ~req_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // Link domain reset
  // ------------------------------------------------------------------
  logic lrst_s1_q;
  logic lrst_n;

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      lrst_s1_q <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n    <= lrst_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Link serialiser
  // ------------------------------------------------------------------
  logic        lreq_s1_q;
  logic        lreq_s2_q;
  logic [15:0] lsh_q;
  logic [3:0]  lcnt_q;
  logic        lload;

  assign lload = (!head_wr_gate || (lcnt_q == CELL_LAST)) &&
                 (lreq_s2_q != lack_q);

  always_ff @(posedge clk_link or negedge lrst_n) begin
    if (!lrst_n) begin
      lreq_s1_q    <= 1'b0;
      lreq_s2_q    <= 1'b0;
      lack_q       <= 1'b0;
      lsh_q        <= 16'h0000;
      lcnt_q       <= 4'h0;
      head_wr_gate <= 1'b0;
      head_wr_cell <= 1'b0;
    end else begin
      lreq_s1_q <= req_q;
      lreq_s2_q <= lreq_s1_q;
      if (lload) begin
        lack_q       <= ~lack_q;
        head_wr_cell <= word_q[15];
        lsh_q        <= {word_q[14:0], 1'b0};
        lcnt_q       <= 4'h0;
        head_wr_gate <= 1'b1;
      end else if (head_wr_gate && (lcnt_q != CELL_LAST)) begin
        head_wr_cell <= lsh_q[15];
        lsh_q        <= {lsh_q[14:0], 1'b0};
        lcnt_q       <= lcnt_q + 4'h1;
      end else begin
        head_wr_gate <= 1'b0;
        head_wr_cell <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Link deserialiser
  // ------------------------------------------------------------------
  logic        rd_s1_q;
  logic        rd_s2_q;
  logic [15:0] rwin_q;
  logic [15:0] rwin_n;
  logic [3:0]  rcnt_q;
  logic        ralign_q;
  logic        rmark;
  logic [8:0]  rword_q;
  logic        rtog_q;

  assign rwin_n = {rwin_q[14:0], rd_s2_q};
  assign rmark  = (rwin_n == fm_word(CLK_MARK, MARK_ADDR)) ||
                  (rwin_n == fm_word(CLK_MARK, MARK_DATA)) ||
                  (rwin_n == fm_word(CLK_MARK, MARK_DELETED));

  always_ff @(posedge clk_link or negedge lrst_n) begin
    if (!lrst_n) begin
      rd_s1_q  <= 1'b0;
      rd_s2_q  <= 1'b0;
      rwin_q   <= 16'h0000;
      rcnt_q   <= 4'h0;
      ralign_q <= 1'b0;
      rword_q  <= 9'h000;
      rtog_q   <= 1'b0;
    end else begin
      rd_s1_q <= head_rd_cell;
      rd_s2_q <= rd_s1_q;
      rwin_q  <= rwin_n;
      if (rmark) begin
        ralign_q <= 1'b1;
        rcnt_q   <= 4'h0;
        rword_q  <= {1'b1, fm_data(rwin_n)};
        rtog_q   <= ~rtog_q;
      end else if (ralign_q) begin
        rcnt_q <= rcnt_q + 4'h1;
        if (rcnt_q == CELL_LAST) begin
          rword_q <= {1'b0, fm_data(rwin_n)};
          rtog_q  <= ~rtog_q;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Received field checking
  // ------------------------------------------------------------------
  logic        stog_s1_q;
  logic        stog_s2_q;
  logic        stog_s3_q;
  logic        sbyte;
  logic [7:0]  srem_q;
  logic [15:0] scrc_q;
  logic [15:0] scrc_n;

  assign sbyte  = stog_s2_q ^ stog_s3_q;
  assign scrc_n = crc_byte(scrc_q, rword_q[7:0]);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stog_s1_q     <= 1'b0;
      stog_s2_q     <= 1'b0;
      stog_s3_q     <= 1'b0;
      srem_q        <= 8'h00;
      scrc_q        <= CRC_PRESET;
      rd_mark_valid <= 1'b0;
      rd_mark_kind  <= KIND_NONE;
      rd_valid      <= 1'b0;
      rd_data       <= 8'h00;
      rd_field_done <= 1'b0;
      rd_crc_err    <= 1'b0;
    end else begin
      stog_s1_q     <= rtog_q;
      stog_s2_q     <= stog_s1_q;
      stog_s3_q     <= stog_s2_q;
      rd_mark_valid <= 1'b0;
      rd_valid      <= 1'b0;
      rd_field_done <= 1'b0;
      if (sbyte && rword_q[8]) begin
        rd_mark_valid <= 1'b1;
        scrc_q        <= crc_byte(CRC_PRESET, rword_q[7:0]);
        if (rword_q[7:0] == MARK_ADDR) begin
          rd_mark_kind <= KIND_ID;
          srem_q       <= RD_ID_REMAIN;
        end else if (rword_q[7:0] == MARK_DELETED) begin
          rd_mark_kind <= KIND_DELETED;
          srem_q       <= RD_DATA_REMAIN;
        end else begin
          rd_mark_kind <= KIND_DATA;
          srem_q       <= RD_DATA_REMAIN;
        end
      end else if (sbyte && (srem_q != 8'h00)) begin
        scrc_q  <= scrc_n;
        srem_q  <= srem_q - 8'h01;
        rd_data <= rword_q[7:0];
        if (srem_q > LEN_CRC) begin
          rd_valid <= 1'b1;
        end
        if (srem_q == LEN_ONE) begin
          rd_field_done <= 1'b1;
          rd_crc_err    <= (scrc_n != CRC_GOOD);
        end
      end
    end
  end

endmodule : fmtf_formatter

/* File: sim/fmtf_formatter_sva.sv */
// Port checker for the track formatter.
// Bound to fmtf_formatter; sees its ports only.
module fmtf_formatter_sva
  import fmtf_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  input wire logic                       clk_link,
  input wire logic                       fmt_start,
  input wire logic [fmtf_pkg::PSI_W-1:0] fmt_psi,
  input wire logic                       fmt_busy,
  input wire logic                       fmt_done,
  input wire logic                       fmt_range_err,
  input wire logic                       head_wr_gate,
  input wire logic                       head_wr_cell,
  input wire logic                       rd_mark_valid,
  input wire logic [1:0]                 rd_mark_kind,
  input wire logic                       rd_valid,
  input wire logic                       rd_field_done,
  input wire logic                       rd_crc_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------
  // Payload counter
  // ---------------
  logic [7:0] pay_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pay_q <= 8'h00;
    end else if (rd_mark_valid) begin
      pay_q <= 8'h00;
    end else if (rd_valid) begin
      pay_q <= pay_q + 8'h01;
    end
  end

  chk_range_refuse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fmt_start && !fmt_busy && fmt_psi[9:4] > TRACK_LAST
    |=> fmt_range_err && !fmt_busy)
    else $error("start beyond last track accepted");
  chk_range_take: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fmt_start && !fmt_busy && fmt_psi[9:4] <= TRACK_LAST
    |=> fmt_busy && !fmt_range_err)
    else $error("valid start not taken");
  chk_busy_quiet: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fmt_busy |=> !fmt_range_err)
    else $error("start while busy answered");
  chk_done_end: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(fmt_busy) |-> fmt_done ##1 !fmt_done)
    else $error("busy ended without one done pulse");
  chk_cell_zero: assert property (
    @(posedge clk_link) disable iff (!resetn)
    $rose(head_wr_gate) |-> head_wr_cell)
    else $error("first half cell is not a clock bit");
  chk_mark_kind: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rd_mark_valid |-> rd_mark_kind != KIND_NONE ##1 !rd_mark_valid)
    else $error("bad mark report");
  chk_crc_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $changed(rd_crc_err) |-> rd_field_done)
    else $error("check flag moved outside field end");
  chk_pay_count: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rd_field_done |->
      pay_q == ((rd_mark_kind == KIND_ID) ? 8'h04 : 8'h80))
    else $error("wrong payload byte count in field");
endmodule : fmtf_formatter_sva

bind fmtf_formatter fmtf_formatter_sva u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
  .fmt_start(fmt_start), .fmt_psi(fmt_psi), .fmt_busy(fmt_busy),
  .fmt_done(fmt_done), .fmt_range_err(fmt_range_err),
  .head_wr_gate(head_wr_gate), .head_wr_cell(head_wr_cell),
  .rd_mark_valid(rd_mark_valid), .rd_mark_kind(rd_mark_kind),
  .rd_valid(rd_valid), .rd_field_done(rd_field_done),
  .rd_crc_err(rd_crc_err));

/* File: sim/fmtf_head_model.sv */
// Head model: records written words and plays the stream back.
// Assumes the formatter's link clock on clk_link.
module fmtf_head_model (
  input  wire logic clk_link,
  input  wire logic head_wr_gate,
  input  wire logic head_wr_cell,
  input  wire logic flip,
  output logic      head_rd_cell
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] words[$];
  logic [14:0] sh_q = 15'h0000;
  logic [3:0]  cnt_q = 4'h0;

  initial begin
    head_rd_cell = 1'b0;
  end

  // Flip corrupts data half cells; an idle head gives a toggling line.
  always @(posedge clk_link) begin
    if (head_wr_gate) begin
      sh_q <= {sh_q[13:0], head_wr_cell};
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hF) begin
        words.push_back({sh_q, head_wr_cell});
      end
      head_rd_cell <= head_wr_cell ^ (flip & cnt_q[0]);
    end else begin
      cnt_q <= 4'h0;
      head_rd_cell <= ~head_rd_cell;
    end
  end
endmodule : fmtf_head_model

/* File: sim/fmtf_formatter_tb.sv */
// Self-checking bench for the track formatter.
// Assumes fmtf_head_model as the head on the link.
module fmtf_formatter_tb;
  import fmtf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, clk_link = 1'b1, resetn = 1'b1;
  logic fmt_start = 1'b0, fmt_deleted = 1'b0, wr_valid = 1'b1;
  logic [9:0] fmt_psi = 10'h000;
  logic [7:0] wr_data = 8'h00, rd_data, rd_last;
  logic wr_ready, fmt_busy, fmt_done, fmt_range_err, flip = 1'b0;
  logic head_wr_gate, head_wr_cell, head_rd_cell, rd_mark_valid;
  logic rd_valid, rd_field_done, rd_crc_err;
  logic [1:0] rd_mark_kind;
  logic [3:0] kinds;
  logic [15:0] crc_q;
  int errors = 0, cmp_count = 0, cycles = 0, n_val, n_done, n_err;

  always #5 clk_sys = ~clk_sys;
  always #15 clk_link = ~clk_link;

  fmtf_formatter u_fmtf_formatter (
    .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
    .fmt_start(fmt_start), .fmt_psi(fmt_psi),
    .fmt_deleted(fmt_deleted), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .fmt_busy(fmt_busy),
    .fmt_done(fmt_done), .fmt_range_err(fmt_range_err),
    .head_wr_gate(head_wr_gate), .head_wr_cell(head_wr_cell),
    .head_rd_cell(head_rd_cell), .rd_mark_valid(rd_mark_valid),
    .rd_mark_kind(rd_mark_kind), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_field_done(rd_field_done),
    .rd_crc_err(rd_crc_err));

  fmtf_head_model u_fmtf_head_model (
    .clk_link(clk_link), .head_wr_gate(head_wr_gate),
    .head_wr_cell(head_wr_cell), .flip(flip),
    .head_rd_cell(head_rd_cell));

  // ------------------------
  // Source, monitor, watchdog
  // ------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (wr_valid && wr_ready) wr_data <= wr_data + 8'h01;
    if (rd_mark_valid) kinds <= {kinds[1:0], rd_mark_kind};
    if (rd_valid) n_val++;
    if (rd_valid) rd_last <= rd_data;
    if (rd_field_done) n_done++;
    if (rd_field_done && rd_crc_err) n_err++;
    if (cycles == 60000) begin
      errors++;
      print_verdict();
    end
  end

  function automatic logic [15:0] fm(logic [7:0] c, logic [7:0] d);
    for (int j = 0; j < 8; j++) begin
      fm[2*j+1 -: 2] = {c[j], d[j]};
    end
  endfunction : fm

  function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] d);
    crc16 = c;
    for (int j = 7; j >= 0; j--) begin
      crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ d[j]) ? CRC_POLY : 16'h0);
    end
  endfunction : crc16

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic expect_w(logic [7:0] c, logic [7:0] d, int n);
    repeat (n) begin
      while (u_fmtf_head_model.words.size() == 0) @(posedge clk_sys);
      check("head word", fm(c, d), u_fmtf_head_model.words.pop_front());
      crc_q = crc16(crc_q, d);
    end
  endtask : expect_w

  task automatic do_reset;
    resetn <= 1'b0;
    wr_data <= 8'h00;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask : do_reset

  task automatic start(logic [9:0] psi, logic del);
    @(posedge clk_sys);
    fmt_psi <= psi;
    fmt_deleted <= del;
    fmt_start <= 1'b1;
    @(posedge clk_sys);
    fmt_start <= 1'b0;
    #1;
  endtask : start

  task automatic t_range;
    start(10'h280, 1'b0);
    check("range err", 16'h1, 16'(fmt_range_err));
    check("busy", 16'h0, 16'(fmt_busy));
    @(posedge clk_sys);
    #1 check("range err", 16'h0, 16'(fmt_range_err));
  endtask : t_range

  task automatic t_format(logic [9:0] psi, logic del, logic bad);
    logic [15:0] c;
    u_fmtf_head_model.words.delete();
    {n_val, n_done, n_err} = '0;
    start(psi, del);
    check("busy", 16'h1, 16'(fmt_busy));
    check("done", 16'h0, 16'(fmt_done));
    start(10'h280, 1'b0);
    check("range err", 16'h0, 16'(fmt_range_err));
    expect_w(8'hFF, 8'hFF, 16);
    for (int s = 0; s < 2; s++) begin
      expect_w(8'hFF, 8'h00, 6);
      crc_q = CRC_PRESET;
      expect_w(CLK_MARK, MARK_ADDR, 1);
      expect_w(8'hFF, {2'b00, psi[9:4]}, 1);
      expect_w(8'hFF, 8'h00, 1);
      expect_w(8'hFF, 8'(s), 1);
      expect_w(8'hFF, 8'h00, 1);
      c = crc_q;
      expect_w(8'hFF, c[15:8], 1);
      expect_w(8'hFF, c[7:0], 1);
      if (s == 1) break;
      expect_w(8'hFF, 8'hFF, 11);
      expect_w(8'hFF, 8'h00, 6);
      check("buffer ready", 16'h0, 16'(wr_ready));
      crc_q = CRC_PRESET;
      expect_w(CLK_MARK, del ? MARK_DELETED : MARK_DATA, 1);
      for (int i = 0; i < 128; i++) begin
        flip = bad && i >= 8 && i < 12;
        expect_w(8'hFF, 8'(i), 1);
      end
      c = crc_q;
      expect_w(8'hFF, c[15:8], 1);
      expect_w(8'hFF, c[7:0], 1);
      expect_w(8'hFF, 8'hFF, 27);
      check("mark kinds", {KIND_ID, del ? KIND_DELETED : KIND_DATA},
            16'(kinds));
      check("payload bytes", 16'd132, 16'(n_val));
      check("fields", 16'h2, 16'(n_done));
      check("check errors", 16'(bad), 16'(n_err));
      check("last read byte", 16'h007F, 16'(rd_last));
      check("read check byte", {8'h00, c[7:0]}, 16'(rd_data));
    end
    do_reset();
  endtask : t_format

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    do_reset();
    t_range();
    t_format(10'h270, 1'b0, 1'b0);
    t_format(10'h123, 1'b1, 1'b1);
    print_verdict();
  end
endmodule : fmtf_formatter_tb
